// File: logic/bcb_cond.sv
// Branch condition evaluator for opcodes 20 to 2F.
// Assumes the caller only trusts take for opcodes in that range.
`timescale 1ns/1ps
`default_nettype none
module bcb_cond (
    bcb_cond_if.eval cif
);
    import bcb_pkg::*;
    logic n, z, v, c;
    always_comb begin
        n = cif.condition_code_register[CCR_N];
        z = cif.condition_code_register[CCR_Z];
        v = cif.condition_code_register[CCR_V];
        c = cif.condition_code_register[CCR_C];
        case (cif.opcode[3:0])
            BR_ALWAYS: cif.take = 1'b1;
            BR_NEVER: cif.take = 1'b0;
            BR_UGT: cif.take = !(c | z);
            BR_ULE: cif.take = c | z;
            BR_CARRY_CLR: cif.take = !c;
            BR_CARRY_SET: cif.take = c;
            BR_NOT_EQUAL: cif.take = !z;
            BR_EQUAL: cif.take = z;
            BR_NO_OVF: cif.take = !v;
            BR_OVF: cif.take = v;
            BR_POSITIVE: cif.take = !n;
            BR_NEGATIVE: cif.take = n;
            BR_SGE: cif.take = !(n ^ v);
            BR_SLT: cif.take = n ^ v;
            BR_SGT: cif.take = !(z | (n ^ v));
            BR_SLE: cif.take = z | (n ^ v);
            default: cif.take = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// File: logic/bcb_cond_if.sv
// Carries the branch opcode and condition codes to the condition evaluator.
// Assumes both ends sit in the same clock domain; the path is combinational.
`timescale 1ns/1ps
`default_nettype none
interface bcb_cond_if;
    logic [7:0] opcode;
    logic [7:0] condition_code_register;
    logic take;
    modport core (output opcode, output condition_code_register, input take);
    modport eval (input opcode, input condition_code_register, output take);
endinterface
`default_nettype wire

// File: logic/bcb_exec.sv
// Executes memory bit-clear and the conditional relative branches.
// Assumes memory answers a read in the same bus cycle; DIN is sampled at its end.
`timescale 1ns/1ps
`default_nettype none
module bcb_exec (
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic [7:0] DIN,
    input wire logic [15:0] IX,
    input wire logic [15:0] IY,
    input wire logic CCR_LOAD,
    input wire logic [7:0] CCR_IN,
    output logic [15:0] ADDR,
    output logic [7:0] DOUT,
    output logic RW,
    output logic [15:0] PC,
    output logic [7:0] CONDITION_CODE_REGISTER,
    output logic SYNC,
    output logic ILLEGAL
);
    import bcb_pkg::*;

    logic rst_meta_r, rst_n;
    bcb_state_type state_r, state_nxt;
    bcb_mode_type mode_r, mode_nxt;
    logic [15:0] pc_r, pc_nxt, addr_r, addr_nxt, ea_r, ea_nxt;
    logic [7:0] op_r, op_nxt, off_r, off_nxt, opnd_r, opnd_nxt, mask_r, mask_nxt;
    logic [7:0] dout_r, dout_nxt, ccr_r, ccr_nxt;
    logic rw_r, rw_nxt, sync_r, sync_nxt, ill_r, ill_nxt, take_r, take_nxt;
    logic [7:0] result;

    bcb_cond_if cif ();
    bcb_cond u_cond (.cif(cif));
    assign cif.opcode = op_r;
    assign cif.condition_code_register = ccr_r;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    function automatic logic [15:0] pc_inc(input logic [15:0] p);
        pc_inc = p + 16'h0001;
    endfunction

    assign result = opnd_r & ~mask_r;

    always_comb begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        pc_nxt = pc_r;
        addr_nxt = addr_r;
        ea_nxt = ea_r;
        op_nxt = op_r;
        off_nxt = off_r;
        opnd_nxt = opnd_r;
        mask_nxt = mask_r;
        dout_nxt = dout_r;
        ccr_nxt = ccr_r;
        rw_nxt = 1'b1;
        sync_nxt = 1'b0;
        ill_nxt = 1'b0;
        take_nxt = take_r;
        case (state_r)
            ST_FETCH: begin
                op_nxt = DIN;
                pc_nxt = pc_inc(pc_r);
                addr_nxt = pc_inc(pc_r);
                if (DIN == OP_CLR_DIR) begin
                    mode_nxt = AM_DIR;
                    state_nxt = ST_ADDR;
                end else if (DIN == OP_CLR_IDX) begin
                    mode_nxt = AM_X;
                    state_nxt = ST_ADDR;
                end else if (DIN == OP_PREBYTE_Y) begin
                    state_nxt = ST_PREBYTE;
                end else if (DIN[7:4] == OP_BR_HI) begin
                    state_nxt = ST_BR_OFF;
                end else begin
                    // Foreign opcodes are skipped as one-byte no-ops
                    ill_nxt = 1'b1;
                    sync_nxt = 1'b1;
                end
            end
            ST_PREBYTE: begin
                pc_nxt = pc_inc(pc_r);
                addr_nxt = pc_inc(pc_r);
                if (DIN == OP_CLR_IDX) begin
                    mode_nxt = AM_Y;
                    state_nxt = ST_ADDR;
                end else begin
                    ill_nxt = 1'b1;
                    sync_nxt = 1'b1;
                    state_nxt = ST_FETCH;
                end
            end
            ST_ADDR: begin
                pc_nxt = pc_inc(pc_r);
                off_nxt = DIN;
                if (mode_r == AM_DIR) begin
                    ea_nxt = {DIRECT_PAGE, DIN};
                    addr_nxt = {DIRECT_PAGE, DIN};
                    state_nxt = ST_READ_OP;
                end else begin
                    addr_nxt = IDLE_ADDR;
                    state_nxt = ST_IDLE_IX;
                end
            end
            ST_IDLE_IX: begin
                ea_nxt = ((mode_r == AM_Y) ? IY : IX) + {8'h00, off_r};
                addr_nxt = ea_nxt;
                state_nxt = ST_READ_OP;
            end
            ST_READ_OP: begin
                opnd_nxt = DIN;
                addr_nxt = pc_r;
                state_nxt = ST_MASK;
            end
            ST_MASK: begin
                mask_nxt = DIN;
                pc_nxt = pc_inc(pc_r);
                addr_nxt = IDLE_ADDR;
                state_nxt = ST_IDLE_MOD;
            end
            ST_IDLE_MOD: begin
                addr_nxt = ea_r;
                rw_nxt = 1'b0;
                dout_nxt = result;
                ccr_nxt[CCR_N] = result[7];
                ccr_nxt[CCR_Z] = (result == BYTE_ZERO);
                ccr_nxt[CCR_V] = 1'b0;
                state_nxt = ST_WRITE;
            end
            ST_WRITE: begin
                addr_nxt = pc_r;
                sync_nxt = 1'b1;
                state_nxt = ST_FETCH;
            end
            ST_BR_OFF: begin
                off_nxt = DIN;
                pc_nxt = pc_inc(pc_r);
                take_nxt = cif.take;
                addr_nxt = IDLE_ADDR;
                state_nxt = ST_BR_IDLE;
            end
            ST_BR_IDLE: begin
                // Condition was latched a cycle early so a late flag load cannot flip it
                if (take_r) begin
                    pc_nxt = pc_r + {{8{off_r[7]}}, off_r};
                end
                addr_nxt = pc_nxt;
                sync_nxt = 1'b1;
                state_nxt = ST_FETCH;
            end
            default: begin
                addr_nxt = pc_r;
                state_nxt = ST_FETCH;
            end
        endcase
        // Outside core owns the flags; its load outranks a bit-clear update
        if (CCR_LOAD) begin
            ccr_nxt = CCR_IN;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_FETCH;
            mode_r <= AM_DIR;
            pc_r <= PC_RESET;
            addr_r <= PC_RESET;
            ea_r <= PC_RESET;
            op_r <= BYTE_ZERO;
            off_r <= BYTE_ZERO;
            opnd_r <= BYTE_ZERO;
            mask_r <= BYTE_ZERO;
            dout_r <= BYTE_ZERO;
            ccr_r <= CCR_RESET;
            rw_r <= 1'b1;
            sync_r <= 1'b1;
            ill_r <= 1'b0;
            take_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            pc_r <= pc_nxt;
            addr_r <= addr_nxt;
            ea_r <= ea_nxt;
            op_r <= op_nxt;
            off_r <= off_nxt;
            opnd_r <= opnd_nxt;
            mask_r <= mask_nxt;
            dout_r <= dout_nxt;
            ccr_r <= ccr_nxt;
            rw_r <= rw_nxt;
            sync_r <= sync_nxt;
            ill_r <= ill_nxt;
            take_r <= take_nxt;
        end
    end

    assign ADDR = addr_r;
    assign DOUT = dout_r;
    assign RW = rw_r;
    assign PC = pc_r;
    assign CONDITION_CODE_REGISTER = ccr_r;
    assign SYNC = sync_r;
    assign ILLEGAL = ill_r;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!rst_n);

    sequence clr_tail_s;
        (state_r == ST_WRITE && !rw_r) ##1 (state_r == ST_FETCH && rw_r);
    endsequence
    sequence br_tail_s;
        (state_r == ST_BR_IDLE && addr_r == IDLE_ADDR && rw_r) ##1 (state_r == ST_FETCH);
    endsequence

    dir_length_a: assert property ((state_r == ST_FETCH && DIN == OP_CLR_DIR) |=> ##4 clr_tail_s)
        else $error("direct bit-clear length wrong");
    idx_length_a: assert property ((state_r == ST_FETCH && DIN == OP_CLR_IDX) |=> ##5 clr_tail_s)
        else $error("x-indexed bit-clear length wrong");
    idle_write_a: assert property ((state_r == ST_MASK) |=> (addr_r == IDLE_ADDR && rw_r) ##1
        (addr_r == ea_r && !rw_r)) else $error("bit-clear idle or write cycle wrong");
    clear_flags_a: assert property ((state_r == ST_WRITE && !$past(CCR_LOAD)) |-> (ccr_r[CCR_N] == dout_r[7]
        && ccr_r[CCR_Z] == (dout_r == BYTE_ZERO) && !ccr_r[CCR_V] && ccr_r[CCR_C] == $past(ccr_r[CCR_C])))
        else $error("bit-clear flags wrong");
    mask_clear_a: assert property ((state_r == ST_WRITE) |-> dout_r == ($past(DIN, 3) & ~$past(DIN, 2)))
        else $error("bit-clear result wrong");
    y_length_a: assert property ((state_r == ST_PREBYTE && DIN == OP_CLR_IDX) |=> ##5 clr_tail_s)
        else $error("y-indexed bit-clear length wrong");
    br_cycles_a: assert property ((state_r == ST_FETCH && DIN[7:4] == OP_BR_HI) |=>
        (addr_r == $past(pc_r) + 16'h0001 && rw_r) ##1 br_tail_s) else $error("branch bus sequence wrong");
    br_flags_a: assert property ((state_r == ST_BR_OFF && !CCR_LOAD) |=> ccr_r == $past(ccr_r))
        else $error("branch altered flags");
    br_target_a: assert property ((state_r == ST_BR_OFF) |=> ##1 (pc_r == ($past(take_r) ?
        $past(pc_r, 3) + BR_PC_STEP + {{8{$past(off_r[7])}}, $past(off_r)} : $past(pc_r, 3) + BR_PC_STEP)))
        else $error("branch target wrong");
    sge_cond_a: assert property ((state_r == ST_BR_OFF && op_r == {OP_BR_HI, BR_SGE}) |=>
        take_r == !($past(ccr_r[CCR_N]) ^ $past(ccr_r[CCR_V]))) else $error("signed ge decision wrong");
    eq_cond_a: assert property ((state_r == ST_BR_OFF && op_r == {OP_BR_HI, BR_EQUAL}) |=>
        take_r == $past(ccr_r[CCR_Z])) else $error("equal decision wrong");
endmodule
`default_nettype wire

// File: logic/bcb_pkg.sv
// Constants for the bit-clear and relative-branch executor.
// Assumes an 8-bit core with a 16-bit address bus and separate data-in and data-out buses.
package bcb_pkg;
    localparam logic [7:0] OP_CLR_DIR = 8'h15;
    localparam logic [7:0] OP_CLR_IDX = 8'h1D;
    localparam logic [7:0] OP_PREBYTE_Y = 8'h18;
    localparam logic [3:0] OP_BR_HI = 4'h2;
    localparam logic [3:0] BR_ALWAYS = 4'h0;
    localparam logic [3:0] BR_NEVER = 4'h1;
    localparam logic [3:0] BR_UGT = 4'h2;
    localparam logic [3:0] BR_ULE = 4'h3;
    localparam logic [3:0] BR_CARRY_CLR = 4'h4;
    localparam logic [3:0] BR_CARRY_SET = 4'h5;
    localparam logic [3:0] BR_NOT_EQUAL = 4'h6;
    localparam logic [3:0] BR_EQUAL = 4'h7;
    localparam logic [3:0] BR_NO_OVF = 4'h8;
    localparam logic [3:0] BR_OVF = 4'h9;
    localparam logic [3:0] BR_POSITIVE = 4'hA;
    localparam logic [3:0] BR_NEGATIVE = 4'hB;
    localparam logic [3:0] BR_SGE = 4'hC;
    localparam logic [3:0] BR_SLT = 4'hD;
    localparam logic [3:0] BR_SGT = 4'hE;
    localparam logic [3:0] BR_SLE = 4'hF;
    localparam int CCR_N = 3;
    localparam int CCR_Z = 2;
    localparam int CCR_V = 1;
    localparam int CCR_C = 0;
    localparam logic [15:0] IDLE_ADDR = 16'hFFFF;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] CCR_RESET = 8'hD0;
    localparam logic [15:0] BR_PC_STEP = 16'h0002;
    localparam logic [7:0] DIRECT_PAGE = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [3:0] {
        ST_FETCH = 4'h0,
        ST_PREBYTE = 4'h1,
        ST_ADDR = 4'h2,
        ST_IDLE_IX = 4'h3,
        ST_READ_OP = 4'h4,
        ST_MASK = 4'h5,
        ST_IDLE_MOD = 4'h6,
        ST_WRITE = 4'h7,
        ST_BR_OFF = 4'h8,
        ST_BR_IDLE = 4'h9
    } bcb_state_type;

    typedef enum logic [1:0] {
        AM_DIR = 2'h0,
        AM_X = 2'h1,
        AM_Y = 2'h2
    } bcb_mode_type;
endpackage

// File: verif/bcb_exec_tb.sv
// Self-checking bench for the bit-clear and relative-branch executor.
// Assumes bcb_mem answers every read in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module bcb_exec_tb;
    import bcb_pkg::*;
    logic clk, arst_n, ccr_load, rw, sync, illegal;
    logic [7:0] din, dout, ccr_in, condition_code_register;
    logic [15:0] ix, iy, addr, pc, pc_q;
    logic [31:0] r;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 32'hcc6a7548;

    bcb_exec dut (.SYS_CLK(clk), .ARST_N(arst_n), .DIN(din), .IX(ix), .IY(iy), .CCR_LOAD(ccr_load),
        .CCR_IN(ccr_in), .ADDR(addr), .DOUT(dout), .RW(rw), .PC(pc), .CONDITION_CODE_REGISTER(condition_code_register), .SYNC(sync), .ILLEGAL(illegal));
    bcb_mem mem_i (.clk(clk), .addr(addr), .rw(rw), .dout(dout), .din(din));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic close_out();
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Ceiling well above the roughly 2300 cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        num_checks++;
        if (exp !== got) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(logic [15:0] a, logic w);
        chk("ADDR", a, addr);
        chk("RW", {15'h0000, w}, {15'h0000, rw});
        @(negedge clk);
    endtask

    // Opcode fetch cycle; flags are loaded here so the offset cycle sees them
    task automatic start(logic [7:0] f);
        chk("SYNC", 16'h0001, {15'h0000, sync});
        chk("ILLEGAL", 16'h0000, {15'h0000, illegal});
        ccr_load = 1'b1;
        ccr_in = f;
        bus(pc_q, 1'b1);
        ccr_load = 1'b0;
    endtask

    function automatic logic take(logic [7:0] op, logic [7:0] f);
        logic n, z, v, c, t;
        n = f[CCR_N];
        z = f[CCR_Z];
        v = f[CCR_V];
        c = f[CCR_C];
        case (op[3:1])
            3'h0: t = 1'b1;
            3'h1: t = !(c | z);
            3'h2: t = !c;
            3'h3: t = !z;
            3'h4: t = !v;
            3'h5: t = !n;
            3'h6: t = !(n ^ v);
            default: t = !(z | (n ^ v));
        endcase
        return t ^ op[0];
    endfunction

    task automatic branch(logic [7:0] op, logic [7:0] rr, logic [7:0] f);
        logic [15:0] tgt;
        mem_i.mem[IDLE_ADDR] = 8'($random(seed));
        tgt = pc_q + BR_PC_STEP + (take(op, f) ? {{8{rr[7]}}, rr} : 16'h0000);
        mem_i.mem[pc_q] = op;
        mem_i.mem[pc_q + 16'h0001] = rr;
        start(f);
        bus(pc_q + 16'h0001, 1'b1);
        bus(IDLE_ADDR, 1'b1);
        chk("PC", tgt, pc);
        chk("CONDITION_CODE_REGISTER", {8'h00, f}, {8'h00, condition_code_register});
        pc_q = tgt;
    endtask

    task automatic clear_bits_in_memory(logic [1:0] mode, logic [7:0] mask, logic [7:0] opnd, logic [7:0] f);
        logic [15:0] ea, base, q;
        logic [7:0] off, res, exp;
        mem_i.mem[IDLE_ADDR] = 8'($random(seed));
        do begin
            off = 8'($random(seed));
            base = (mode == 2'h0) ? 16'h0000 : 16'($random(seed));
            ea = base + {8'h00, off};
        end while (ea - pc_q < 16'h0004 || ea == IDLE_ADDR);
        ix = (mode == 2'h1) ? base : ~base;
        iy = (mode == 2'h2) ? base : ~base;
        q = pc_q + ((mode == 2'h2) ? 16'h0001 : 16'h0000);
        mem_i.mem[pc_q] = OP_PREBYTE_Y;
        mem_i.mem[q] = (mode == 2'h0) ? OP_CLR_DIR : OP_CLR_IDX;
        mem_i.mem[q + 16'h0001] = off;
        mem_i.mem[q + 16'h0002] = mask;
        mem_i.mem[ea] = opnd;
        res = opnd & ~mask;
        start(f);
        if (mode == 2'h2) bus(pc_q + 16'h0001, 1'b1);
        bus(q + 16'h0001, 1'b1);
        if (mode != 2'h0) bus(IDLE_ADDR, 1'b1);
        bus(ea, 1'b1);
        bus(q + 16'h0002, 1'b1);
        bus(IDLE_ADDR, 1'b1);
        chk("DOUT", {8'h00, res}, {8'h00, dout});
        bus(ea, 1'b0);
        exp = f;
        exp[CCR_N] = res[7];
        exp[CCR_Z] = (res == BYTE_ZERO);
        exp[CCR_V] = 1'b0;
        chk("CONDITION_CODE_REGISTER", {8'h00, exp}, {8'h00, condition_code_register});
        pc_q = q + 16'h0003;
    endtask

    initial begin
        arst_n = 1'b0;
        ccr_load = 1'b0;
        ccr_in = 8'h00;
        ix = 16'h0000;
        iy = 16'h0000;
        pc_q = PC_RESET;
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        // Internal copy lifts at the second edge; the first fetch ends at the third
        repeat (2) @(negedge clk);
        branch(8'h20, 8'h80, 8'h00);
        branch(8'h20, 8'h7F, 8'hFF);
        for (int op = 0; op < 16; op++) begin
            for (int f = 0; f < 16; f++) begin
                branch({4'h2, 4'(op)}, 8'($random(seed)), {4'($random(seed)), 4'(f)});
            end
        end
        for (int m = 0; m < 3; m++) begin
            clear_bits_in_memory(2'(m), 8'hFF, 8'h5A, 8'h0F);
            clear_bits_in_memory(2'(m), 8'h00, 8'h80, 8'h02);
        end
        for (int i = 0; i < 300; i++) begin
            r = 32'($random(seed));
            if (r[2]) begin
                branch({4'h2, r[7:4]}, r[15:8], r[23:16]);
            end else begin
                clear_bits_in_memory((r[4:3] == 2'h3) ? 2'h0 : r[4:3], r[15:8], r[23:16], r[31:24]);
            end
        end
        // Foreign opcode, then a prebyte with the direct bit-clear opcode behind it: both skipped
        mem_i.mem[pc_q] = 8'h01;
        mem_i.mem[pc_q + 16'h0001] = OP_PREBYTE_Y;
        mem_i.mem[pc_q + 16'h0002] = OP_CLR_DIR;
        bus(pc_q, 1'b1);
        chk("ILLEGAL", 16'h0001, {15'h0000, illegal});
        bus(pc_q + 16'h0001, 1'b1);
        bus(pc_q + 16'h0002, 1'b1);
        chk("ILLEGAL", 16'h0001, {15'h0000, illegal});
        chk("ADDR", pc_q + 16'h0003, addr);
        close_out();
    end
endmodule
`default_nettype wire

// File: verif/bcb_mem.sv
// Zero-wait byte memory on the far side of the executor's bus.
// Assumes the bench preloads code and data through mem.
`timescale 1ns/1ps
`default_nettype none
module bcb_mem (
    input wire logic clk,
    input wire logic [15:0] addr,
    input wire logic rw,
    input wire logic [7:0] dout,
    output logic [7:0] din
);
    logic [7:0] mem [0:65535];
    // Inverted data while the core writes, so a stray sample is caught
    assign din = rw ? mem[addr] : ~mem[addr];
    always @(posedge clk) begin
        if (!rw) begin
            mem[addr] <= dout;
        end
    end
endmodule
`default_nettype wire
